// file: core/zone_cmd_pkg.sv
package zone_cmd_pkg;
	localparam int WORD_W = 16;
	localparam int ADDR_W = 12;
	localparam int ZONE_UP = 0;
	localparam int ZONE_DN = 1;

	// index 0 is the upstream zone or left roller, 1 downstream or right, except the induct pairs where 0 is word1 and 1 is word2
	localparam logic [1:0][11:0] TRK1_OFS = {12'h642, 12'h640};
	localparam logic [1:0][11:0] TRK2_OFS = {12'h643, 12'h641};
	localparam logic [1:0][11:0] ACC_OFS = {12'h645, 12'h644};
	localparam logic [1:0][11:0] SPD_OFS = {12'h647, 12'h646};
	localparam logic [1:0][11:0] REL_OFS = {12'h649, 12'h648};
	localparam logic [11:0] INDUCT_OFS = 12'h64A;
	localparam logic [11:0] DISCH_OFS = 12'h64B;
	localparam logic [1:0][11:0] IND_FWD_OFS = {12'h64D, 12'h64C};
	localparam logic [1:0][11:0] IND_REV_OFS = {12'h64F, 12'h64E};
	localparam logic [11:0] MERR_OFS = 12'h650;
	localparam logic [11:0] AUX_OFS = 12'h651;
	localparam logic [11:0] RSVD_OFS = 12'h652;

	localparam int ACC_MODE_BIT = 0;
	localparam int ACC_UPACC_BIT = 8;
	localparam int ACC_ARRIVE_BIT = 9;
	localparam int ACC_JOGF_BIT = 10;
	localparam int ACC_JOGR_BIT = 11;
	localparam int ACC_WAKE_BIT = 12;
	localparam int ACC_MAINT_BIT = 13;
	localparam logic [15:0] ACC_MASK = 16'h3F01;

	localparam int AUX_DIR_LSB = 8;
	localparam int AUX_LVL_LSB = 12;

	localparam logic [15:0] INDUCT_RUN_CMD = 16'h0004;
	localparam logic [15:0] INDUCT_TAKE_CMD = 16'h0001;
	localparam logic [15:0] DIS_HOLD_CMD = 16'h0005;
	localparam logic [15:0] DIS_PERMIT_CMD = 16'h0001;
	localparam logic [15:0] MERR_OFF = 16'h0000;
	localparam logic [15:0] MERR_ON = 16'h0001;
	localparam logic [15:0] TRK_KEEP = 16'h0000;
	localparam logic [15:0] TRK_CLEAR = 16'hFFFF;
	localparam logic [15:0] WORD_ZERO = 16'h0000;
endpackage

// file: core/zone_output_command_regs.sv
module zone_output_command_regs #(
	parameter logic [15:0] SPEED_RST = 16'h0000
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_wr_en,
	input wire logic [11:0] i_wr_addr,
	input wire logic [15:0] i_wr_data,
	input wire logic i_reverse,
	input wire logic [1:0] i_arrival,
	output logic [1:0] o_accum_mode,
	output logic [1:0] o_accum_upstream,
	output logic [1:0] o_arrival_confirm,
	output logic [1:0] o_jog_fwd,
	output logic [1:0] o_jog_rev,
	output logic [1:0] o_wake,
	output logic [1:0] o_maint,
	output logic [1:0] o_release,
	output logic [1:0] o_hold_next,
	output logic [1:0][15:0] o_trk_word1,
	output logic [1:0][15:0] o_trk_word2,
	output logic [1:0][15:0] o_roller_speed,
	output logic o_induct_run,
	output logic o_discharge_hold,
	output logic o_discharge_permit,
	output logic o_motor_err_reset,
	output logic [1:0] o_aux_oe,
	output logic [1:0] o_aux_out
);

	typedef struct packed {
		logic [1:0][15:0] hold1;
		logic [1:0][15:0] hold2;
		logic [1:0][15:0] trk1;
		logic [1:0][15:0] trk2;
		logic [1:0][15:0] acc;
		logic [1:0][15:0] speed;
		logic [1:0][15:0] rel_val;
		logic [1:0][15:0] ind_fwd;
		logic [1:0][15:0] ind_rev;
		logic [1:0] rel;
		logic [1:0] armed;
		logic [1:0] aux_oe;
		logic [1:0] aux_out;
		logic induct_run;
		logic dis_hold;
		logic dis_permit;
		logic merr;
	} state_s;

	state_s s_r;
	state_s s_nxt;
	logic [1:0] rel_go;
	logic induct_take;

	function automatic logic is_wr(
		input logic en,
		input logic [11:0] addr,
		input logic [11:0] ofs
	);
		is_wr = en && (addr == ofs);
	endfunction

	// returns {word1, word2} for the real tracking data
	function automatic logic [31:0] resolve(
		input logic [15:0] cur1,
		input logic [15:0] cur2,
		input logic [15:0] new1,
		input logic [15:0] new2
	);
		logic [31:0] res;
		res = {new1, new2};
		if (new1 == zone_cmd_pkg::TRK_KEEP &&
			new2 == zone_cmd_pkg::TRK_KEEP) begin
			res = {cur1, cur2};
		end else if (new1 == zone_cmd_pkg::TRK_CLEAR &&
			new2 == zone_cmd_pkg::TRK_CLEAR) begin
			res = {zone_cmd_pkg::WORD_ZERO, zone_cmd_pkg::WORD_ZERO};
		end
		resolve = res;
	endfunction

	function automatic logic bit_of(
		input logic [15:0] w,
		input int b
	);
		bit_of = w[b];
	endfunction

	always_comb begin
		s_nxt = s_r;
		rel_go = 2'h0;
		induct_take = 1'h0;
		s_nxt.rel = 2'h0;
		for (int z = 0; z < 2; z++) begin
			// tracking words only land in holding storage here
			if (is_wr(i_wr_en, i_wr_addr,
				zone_cmd_pkg::TRK1_OFS[z])) begin
				s_nxt.hold1[z] = i_wr_data;
			end
			if (is_wr(i_wr_en, i_wr_addr,
				zone_cmd_pkg::TRK2_OFS[z])) begin
				s_nxt.hold2[z] = i_wr_data;
			end
			// reserved control bits are dropped on write
			if (is_wr(i_wr_en, i_wr_addr,
				zone_cmd_pkg::ACC_OFS[z])) begin
				s_nxt.acc[z] = i_wr_data & zone_cmd_pkg::ACC_MASK;
			end
			// zero is not a stop command, so the old setpoint stays
			if (is_wr(i_wr_en, i_wr_addr, zone_cmd_pkg::SPD_OFS[z]) &&
				i_wr_data != zone_cmd_pkg::WORD_ZERO) begin
				s_nxt.speed[z] = i_wr_data;
			end
			if (is_wr(i_wr_en, i_wr_addr,
				zone_cmd_pkg::REL_OFS[z])) begin
				s_nxt.rel_val[z] = i_wr_data;
				rel_go[z] = s_r.acc[z][zone_cmd_pkg::ACC_MODE_BIT] &&
					(i_wr_data != s_r.rel_val[z]);
			end
			if (is_wr(i_wr_en, i_wr_addr,
				zone_cmd_pkg::IND_FWD_OFS[z])) begin
				s_nxt.ind_fwd[z] = i_wr_data;
			end
			if (is_wr(i_wr_en, i_wr_addr,
				zone_cmd_pkg::IND_REV_OFS[z])) begin
				s_nxt.ind_rev[z] = i_wr_data;
			end
			if (i_arrival[z]) begin
				s_nxt.armed[z] = 1'h0;
			end
			// a release in the arrival cycle still arms the zone
			if (rel_go[z]) begin
				s_nxt.rel[z] = 1'h1;
				s_nxt.armed[z] = 1'h1;
				{s_nxt.trk1[z], s_nxt.trk2[z]} = resolve(s_r.trk1[z],
					s_r.trk2[z], s_r.hold1[z], s_r.hold2[z]);
			end
			if (is_wr(i_wr_en, i_wr_addr, zone_cmd_pkg::AUX_OFS)) begin
				s_nxt.aux_oe[z] =
					i_wr_data[zone_cmd_pkg::AUX_DIR_LSB + z];
				s_nxt.aux_out[z] =
					i_wr_data[zone_cmd_pkg::AUX_LVL_LSB + z] &&
					i_wr_data[zone_cmd_pkg::AUX_DIR_LSB + z];
			end
		end

		// induct handshake with a conveyor outside our control
		if (is_wr(i_wr_en, i_wr_addr, zone_cmd_pkg::INDUCT_OFS)) begin
			if (i_wr_data == zone_cmd_pkg::INDUCT_RUN_CMD) begin
				s_nxt.induct_run = 1'h1;
			end else if (i_wr_data == zone_cmd_pkg::INDUCT_TAKE_CMD) begin
				s_nxt.induct_run = 1'h0;
				induct_take = 1'h1;
			end
		end
		// induct data wins over a same-cycle upstream release copy
		if (induct_take) begin
			if (i_reverse) begin
				{s_nxt.trk1[zone_cmd_pkg::ZONE_UP],
					s_nxt.trk2[zone_cmd_pkg::ZONE_UP]} = resolve(
					s_r.trk1[zone_cmd_pkg::ZONE_UP],
					s_r.trk2[zone_cmd_pkg::ZONE_UP],
					s_r.ind_rev[0], s_r.ind_rev[1]);
			end else begin
				{s_nxt.trk1[zone_cmd_pkg::ZONE_UP],
					s_nxt.trk2[zone_cmd_pkg::ZONE_UP]} = resolve(
					s_r.trk1[zone_cmd_pkg::ZONE_UP],
					s_r.trk2[zone_cmd_pkg::ZONE_UP],
					s_r.ind_fwd[0], s_r.ind_fwd[1]);
			end
		end

		// discharge handshake; other values leave the state alone
		if (is_wr(i_wr_en, i_wr_addr, zone_cmd_pkg::DISCH_OFS)) begin
			if (i_wr_data == zone_cmd_pkg::DIS_HOLD_CMD) begin
				s_nxt.dis_hold = 1'h1;
				s_nxt.dis_permit = 1'h0;
			end else if (i_wr_data == zone_cmd_pkg::DIS_PERMIT_CMD) begin
				s_nxt.dis_hold = 1'h0;
				s_nxt.dis_permit = 1'h1;
			end
		end

		// values other than 0 and 1 are refused
		if (is_wr(i_wr_en, i_wr_addr, zone_cmd_pkg::MERR_OFS)) begin
			if (i_wr_data == zone_cmd_pkg::MERR_ON) begin
				s_nxt.merr = 1'h1;
			end else if (i_wr_data == zone_cmd_pkg::MERR_OFF) begin
				s_nxt.merr = 1'h0;
			end
		end
		// the reserved word at its offset decodes to nothing
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			s_r <= '0;
			s_r.speed <= {SPEED_RST, SPEED_RST};
		end else begin
			s_r <= s_nxt;
		end
	end

	always_comb begin
		for (int z = 0; z < 2; z++) begin
			o_accum_mode[z] = s_r.acc[z][zone_cmd_pkg::ACC_MODE_BIT];
			o_accum_upstream[z] =
				s_r.acc[z][zone_cmd_pkg::ACC_UPACC_BIT];
			o_arrival_confirm[z] =
				s_r.acc[z][zone_cmd_pkg::ACC_ARRIVE_BIT];
			o_jog_fwd[z] = s_r.acc[z][zone_cmd_pkg::ACC_JOGF_BIT];
			o_jog_rev[z] = s_r.acc[z][zone_cmd_pkg::ACC_JOGR_BIT];
			o_wake[z] = s_r.acc[z][zone_cmd_pkg::ACC_WAKE_BIT];
			o_maint[z] = s_r.acc[z][zone_cmd_pkg::ACC_MAINT_BIT];
		end
	end

	assign o_release = s_r.rel;
	assign o_hold_next = s_r.armed;
	assign o_trk_word1 = s_r.trk1;
	assign o_trk_word2 = s_r.trk2;
	assign o_roller_speed = s_r.speed;
	assign o_induct_run = s_r.induct_run;
	assign o_discharge_hold = s_r.dis_hold;
	assign o_discharge_permit = s_r.dis_permit;
	assign o_motor_err_reset = s_r.merr;
	assign o_aux_oe = s_r.aux_oe;
	assign o_aux_out = s_r.aux_out;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);

	a_speed_zero_keep: assert property (
		is_wr(i_wr_en, i_wr_addr, zone_cmd_pkg::SPD_OFS[0]) &&
		i_wr_data == zone_cmd_pkg::WORD_ZERO
		|=> $stable(o_roller_speed[0])
	) else $error("left speed changed on zero write");

	a_speed_load: assert property (
		is_wr(i_wr_en, i_wr_addr, zone_cmd_pkg::SPD_OFS[1]) &&
		i_wr_data != zone_cmd_pkg::WORD_ZERO
		|=> o_roller_speed[1] == $past(i_wr_data)
	) else $error("right speed not loaded");

	a_release_on_change: assert property (
		is_wr(i_wr_en, i_wr_addr, zone_cmd_pkg::REL_OFS[0]) &&
		o_accum_mode[0] && i_wr_data != s_r.rel_val[0]
		|=> o_release[0] ##1 (!o_release[0] ||
		($past(i_wr_en) && $past(i_wr_addr) == zone_cmd_pkg::REL_OFS[0]))
	) else $error("upstream release pulse wrong");

	a_release_needs_mode: assert property (
		!o_accum_mode[1] |=> !o_release[1]
	) else $error("downstream released outside accumulation");

	a_arm_after_release: assert property (
		o_release[1] && !i_arrival[1] |-> o_hold_next[1] ##1 o_hold_next[1]
	) else $error("zone not armed after release");

	a_trk_clear: assert property (
		rel_go[0] && !induct_take &&
		s_r.hold1[0] == zone_cmd_pkg::TRK_CLEAR &&
		s_r.hold2[0] == zone_cmd_pkg::TRK_CLEAR
		|=> o_trk_word1[0] == zone_cmd_pkg::WORD_ZERO &&
		o_trk_word2[0] == zone_cmd_pkg::WORD_ZERO
	) else $error("tracking not cleared on release");

	a_trk_keep: assert property (
		rel_go[1] && s_r.hold1[1] == zone_cmd_pkg::TRK_KEEP &&
		s_r.hold2[1] == zone_cmd_pkg::TRK_KEEP
		|=> $stable(o_trk_word1[1]) && $stable(o_trk_word2[1])
	) else $error("tracking changed on keep release");

	a_trk_held: assert property (
		!rel_go[1] |=> $stable(o_trk_word1[1])
	) else $error("tracking changed without release");

	a_induct_run: assert property (
		is_wr(i_wr_en, i_wr_addr, zone_cmd_pkg::INDUCT_OFS) &&
		i_wr_data == zone_cmd_pkg::INDUCT_RUN_CMD
		|=> o_induct_run
	) else $error("induct run not set");

	a_discharge_hold: assert property (
		is_wr(i_wr_en, i_wr_addr, zone_cmd_pkg::DISCH_OFS) &&
		i_wr_data == zone_cmd_pkg::DIS_HOLD_CMD
		|=> o_discharge_hold && !o_discharge_permit
	) else $error("discharge hold not set");

	a_merr_filter: assert property (
		is_wr(i_wr_en, i_wr_addr, zone_cmd_pkg::MERR_OFS) &&
		i_wr_data != zone_cmd_pkg::MERR_ON &&
		i_wr_data != zone_cmd_pkg::MERR_OFF
		|=> $stable(o_motor_err_reset)
	) else $error("motor reset took illegal value");

	a_aux_gate: assert property (
		(o_aux_out & ~o_aux_oe) == 2'h0
	) else $error("aux level driven while input");

	a_mode_upstream: assert property (
		is_wr(i_wr_en, i_wr_addr, zone_cmd_pkg::ACC_OFS[0])
		|=> o_accum_mode[0] ==
		bit_of($past(i_wr_data), zone_cmd_pkg::ACC_MODE_BIT)
	) else $error("upstream mode bit not taken");

	a_ctrl_downstream: assert property (
		is_wr(i_wr_en, i_wr_addr, zone_cmd_pkg::ACC_OFS[1])
		|=> o_accum_mode[1] ==
		bit_of($past(i_wr_data), zone_cmd_pkg::ACC_MODE_BIT) &&
		o_maint[1] ==
		bit_of($past(i_wr_data), zone_cmd_pkg::ACC_MAINT_BIT)
	) else $error("downstream control bits not taken");

	a_neighbour_bits: assert property (
		is_wr(i_wr_en, i_wr_addr, zone_cmd_pkg::ACC_OFS[0])
		|=> o_accum_upstream[0] ==
		bit_of($past(i_wr_data), zone_cmd_pkg::ACC_UPACC_BIT) &&
		o_arrival_confirm[0] ==
		bit_of($past(i_wr_data), zone_cmd_pkg::ACC_ARRIVE_BIT)
	) else $error("neighbour zone bits not taken");

	a_jog_bits: assert property (
		is_wr(i_wr_en, i_wr_addr, zone_cmd_pkg::ACC_OFS[1])
		|=> o_jog_fwd[1] ==
		bit_of($past(i_wr_data), zone_cmd_pkg::ACC_JOGF_BIT) &&
		o_jog_rev[1] ==
		bit_of($past(i_wr_data), zone_cmd_pkg::ACC_JOGR_BIT)
	) else $error("jog bits not taken");

	a_induct_stop: assert property (
		is_wr(i_wr_en, i_wr_addr, zone_cmd_pkg::INDUCT_OFS) &&
		i_wr_data == zone_cmd_pkg::INDUCT_TAKE_CMD
		|=> !o_induct_run
	) else $error("induct run not cleared on take");

	a_induct_forward: assert property (
		is_wr(i_wr_en, i_wr_addr, zone_cmd_pkg::INDUCT_OFS) &&
		i_wr_data == zone_cmd_pkg::INDUCT_TAKE_CMD && !i_reverse &&
		s_r.ind_fwd[0] != zone_cmd_pkg::TRK_KEEP &&
		s_r.ind_fwd[0] != zone_cmd_pkg::TRK_CLEAR
		|=> o_trk_word1[0] == s_r.ind_fwd[0] &&
		o_trk_word2[0] == s_r.ind_fwd[1]
	) else $error("forward induct words not taken");

	a_induct_reverse: assert property (
		is_wr(i_wr_en, i_wr_addr, zone_cmd_pkg::INDUCT_OFS) &&
		i_wr_data == zone_cmd_pkg::INDUCT_TAKE_CMD && i_reverse &&
		s_r.ind_rev[0] != zone_cmd_pkg::TRK_KEEP &&
		s_r.ind_rev[0] != zone_cmd_pkg::TRK_CLEAR
		|=> o_trk_word1[0] == s_r.ind_rev[0] &&
		o_trk_word2[0] == s_r.ind_rev[1]
	) else $error("reverse induct words not taken");

	a_discharge_permit: assert property (
		is_wr(i_wr_en, i_wr_addr, zone_cmd_pkg::DISCH_OFS) &&
		i_wr_data == zone_cmd_pkg::DIS_PERMIT_CMD
		|=> o_discharge_permit && !o_discharge_hold
	) else $error("discharge permit not set");

	a_merr_level: assert property (
		is_wr(i_wr_en, i_wr_addr, zone_cmd_pkg::MERR_OFS) &&
		(i_wr_data == zone_cmd_pkg::MERR_ON ||
		i_wr_data == zone_cmd_pkg::MERR_OFF)
		|=> o_motor_err_reset ==
		($past(i_wr_data) == zone_cmd_pkg::MERR_ON)
	) else $error("motor reset request not taken");

	a_aux_dir: assert property (
		is_wr(i_wr_en, i_wr_addr, zone_cmd_pkg::AUX_OFS)
		|=> o_aux_oe[0] ==
		bit_of($past(i_wr_data), zone_cmd_pkg::AUX_DIR_LSB) &&
		o_aux_oe[1] ==
		bit_of($past(i_wr_data), zone_cmd_pkg::AUX_DIR_LSB + 1)
	) else $error("aux direction not taken");

	a_rsvd_ignored: assert property (
		is_wr(i_wr_en, i_wr_addr, zone_cmd_pkg::RSVD_OFS)
		|=> $stable(o_roller_speed) && $stable(o_accum_mode) &&
		$stable(o_aux_out) && $stable(o_motor_err_reset) &&
		$stable(o_induct_run) && $stable(o_trk_word1)
	) else $error("reserved write changed state");

endmodule

// file: verif/plc_output_writer.sv
module plc_output_writer (
	output logic o_wr_en,
	output logic [11:0] o_wr_addr,
	output logic [15:0] o_wr_data
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_wr_en = 1'h0;
		o_wr_addr = 12'h000;
		o_wr_data = 16'h0000;
	end
	// called at a falling edge, one write a cycle, back to back is legal
	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		o_wr_en = 1'h1;
		o_wr_addr = a;
		o_wr_data = d;
	endtask
	// released bus shows inverted values so stale data cannot look valid
	task automatic stop;
		o_wr_en = 1'h0;
		o_wr_addr = ~o_wr_addr;
		o_wr_data = ~o_wr_data;
	endtask
endmodule

// file: verif/zone_output_command_regs_test.sv
module zone_output_command_regs_test;
	timeunit 1ns;
	timeprecision 1ps;
	typedef logic [121:0] snap_t;
	logic i_clk, i_nrst, i_reverse, i_wr_en, taken;
	logic [1:0] i_arrival;
	logic [11:0] i_wr_addr, a;
	logic [15:0] i_wr_data, d;
	logic [1:0] o_accum_mode, o_accum_upstream, o_arrival_confirm, o_jog_fwd;
	logic [1:0] o_jog_rev, o_wake, o_maint, o_release, o_hold_next;
	logic [1:0] o_aux_oe, o_aux_out, rp, hn, oe, ao;
	logic [1:0][15:0] o_trk_word1, o_trk_word2, o_roller_speed;
	logic o_induct_run, o_discharge_hold, o_discharge_permit;
	logic o_motor_err_reset, run, dh, dp, me;
	logic [1:0][15:0] acc, rel, h1, h2, t1, t2, spd, ind1, ind2;
	int n_errors, n_checks, seed;
	logic [31:0] r;
	snap_t q[$];

	zone_output_command_regs dut (.i_clk, .i_nrst, .i_wr_en, .i_wr_addr,
		.i_wr_data, .i_reverse, .i_arrival, .o_accum_mode, .o_accum_upstream,
		.o_arrival_confirm, .o_jog_fwd, .o_jog_rev, .o_wake, .o_maint,
		.o_release, .o_hold_next, .o_trk_word1, .o_trk_word2,
		.o_roller_speed, .o_induct_run, .o_discharge_hold,
		.o_discharge_permit, .o_motor_err_reset, .o_aux_oe, .o_aux_out);
	plc_output_writer plc (.o_wr_en(i_wr_en), .o_wr_addr(i_wr_addr),
		.o_wr_data(i_wr_data));

	initial begin
		i_clk = 1'h0;
		forever #2.5 i_clk = ~i_clk;
	end

	function automatic logic [1:0] ab(int b);
		return {acc[1][b], acc[0][b]};
	endfunction
	function automatic snap_t expv();
		return {ab(0), ab(8), ab(9), ab(10), ab(11), ab(12), ab(13), rp, hn,
			t1, t2, spd, run, dh, dp, me, oe, ao};
	endfunction
	function automatic snap_t got();
		return {o_accum_mode, o_accum_upstream, o_arrival_confirm, o_jog_fwd,
			o_jog_rev, o_wake, o_maint, o_release, o_hold_next, o_trk_word1,
			o_trk_word2, o_roller_speed, o_induct_run, o_discharge_hold,
			o_discharge_permit, o_motor_err_reset, o_aux_oe, o_aux_out};
	endfunction

	task automatic cmp(snap_t e, snap_t g);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %0t exp %h got %h", $time, e, g);
		end
	endtask

	task automatic cp(int z, logic [15:0] n1, logic [15:0] n2);
		if (n1 == 16'hFFFF && n2 == 16'hFFFF) begin
			t1[z] = 16'h0000;
			t2[z] = 16'h0000;
		end else if (n1 != 16'h0000 || n2 != 16'h0000) begin
			t1[z] = n1;
			t2[z] = n2;
		end
	endtask

	// reference update for one write; arrival arrives in the same cycle
	task automatic upd(logic rv);
		rp = 2'h0;
		for (int z = 0; z < 2; z++) begin
			if (a == zone_cmd_pkg::ACC_OFS[z])
				acc[z] = d & zone_cmd_pkg::ACC_MASK;
			if (a == zone_cmd_pkg::SPD_OFS[z] && d != 16'h0000)
				spd[z] = d;
			if (a == zone_cmd_pkg::TRK1_OFS[z])
				h1[z] = d;
			if (a == zone_cmd_pkg::TRK2_OFS[z])
				h2[z] = d;
			if (a == zone_cmd_pkg::IND_FWD_OFS[z])
				ind1[z] = d;
			if (a == zone_cmd_pkg::IND_REV_OFS[z])
				ind2[z] = d;
			if (a == zone_cmd_pkg::REL_OFS[z]) begin
				if (d != rel[z] && acc[z][0]) begin
					rp[z] = 1'h1;
					cp(z, h1[z], h2[z]);
				end
				rel[z] = d;
			end
			hn[z] = rp[z] ? 1'h1 : (i_arrival[z] ? 1'h0 : hn[z]);
		end
		if (a == zone_cmd_pkg::INDUCT_OFS && d == 16'h0004)
			run = 1'h1;
		if (a == zone_cmd_pkg::INDUCT_OFS && d == 16'h0001) begin
			run = 1'h0;
			cp(0, rv ? ind2[0] : ind1[0],
				rv ? ind2[1] : ind1[1]);
		end
		if (a == zone_cmd_pkg::DISCH_OFS && (d == 16'h0005 || d == 16'h0001)) begin
			dh = d[2];
			dp = ~d[2];
		end
		if (a == zone_cmd_pkg::MERR_OFS && d[15:1] == 15'h0000)
			me = d[0];
		if (a == zone_cmd_pkg::AUX_OFS) begin
			oe = d[9:8];
			ao = d[13:12] & d[9:8];
		end
	endtask

	task automatic results;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	always @(posedge i_clk) begin
		taken <= i_wr_en;
	end
	// each write shows its effect at the falling edge half a cycle after the taking edge
	always @(negedge i_clk) begin
		if (taken) begin
			if (q.size() == 0) begin
				n_errors++;
				$display("ERROR %0t exp %h got %h", $time, 1'h1, 1'h0);
			end else begin
				cmp(q.pop_front(), got());
			end
		end
	end

	initial begin
		seed = 76807;
		i_nrst = 1'h0;
		i_reverse = 1'h0;
		i_arrival = 2'h0;
		{acc, rel, h1, h2, t1, t2, spd, ind1, ind2} = '0;
		{rp, hn, oe, ao, run, dh, dp, me} = '0;
		repeat (5) @(negedge i_clk);
		cmp(expv(), got());
		i_nrst = 1'h1;
		// unmapped and reserved places are hit on purpose
		for (int i = 0; i < 600; i++) begin
			@(negedge i_clk);
			r = $random(seed);
			a = 12'h63F + 12'(r[23:19] % 5'd21);
			case (r[18:16])
				3'h0: d = 16'h0000;
				3'h1: d = 16'hFFFF;
				3'h2: d = 16'h0001;
				3'h3: d = 16'h0004;
				3'h4: d = 16'h0005;
				default: d = r[15:0];
			endcase
			i_arrival = r[25:24] & r[27:26];
			i_reverse = r[28];
			upd(r[28]);
			q.push_back(expv());
			plc.wr(a, d);
		end
		@(negedge i_clk);
		i_arrival = 2'h0;
		plc.stop();
		repeat (2) @(negedge i_clk);
		// a second reset mid-run must bring every output back to idle
		i_nrst = 1'h0;
		repeat (2) @(negedge i_clk);
		{acc, t1, t2, spd} = '0;
		{rp, hn, oe, ao, run, dh, dp, me} = '0;
		cmp(expv(), got());
		i_nrst = 1'h1;
		repeat (2) @(negedge i_clk);
		cmp(expv(), got());
		results;
	end

	initial begin
		repeat (20000) @(posedge i_clk);
		n_errors++;
		results;
	end
endmodule
